//--- efsc_pkg.sv
// Package with register map, field layouts, reset values and timing constants of the frame sync control block.
package efsc_pkg;

    localparam int ADDR_W = 12;

    // Printed offsets are word indices; the byte address is four times the index.
    localparam logic [7:0] IDX_PULSE_FLAGS = 8'h4B;
    localparam logic [7:0] IDX_PULSE_IRQ_EN = 8'h4C;
    localparam logic [7:0] IDX_MODE_PRIMARY = 8'h4D;
    localparam logic [7:0] IDX_MODE_CRITERIA = 8'h4E;
    localparam logic [7:0] IDX_SYNC_STATE = 8'h4F;
    localparam logic [7:0] IDX_SYNC_IRQ_EN = 8'h50;
    localparam logic [7:0] IDX_SYNC_FLAGS = 8'h52;

    typedef struct packed {
        logic [3:0] reserved;
        logic unframed_bypass;
        logic crc_error_reframe_en;
        logic auto_reframe_en;
        logic force_reframe;
    } efsc_mode_primary_t;

    typedef struct packed {
        logic nfas_loss_criterion;
        logic cas_search_en;
        logic crc_mf_search_en;
        logic include_nfas_errors;
        logic whole_word_error;
        logic ts16_zero_count_sel;
        logic ts16_zero_check_en;
        logic interwork_search_keep;
    } efsc_mode_criteria_t;

    // Bit 4 down to bit 0 of the sync state, sync flag and sync enable registers.
    typedef struct packed {
        logic interwork;
        logic cas_mf_loss;
        logic crc_mf_loss;
        logic offline_frame_loss;
        logic frame_loss;
    } efsc_sync_t;

    // Bit 1 is the receive pulse offset, bit 0 the transmit pulse offset.
    typedef struct packed {
        logic rx;
        logic tx;
    } efsc_pulse_t;

    typedef struct packed {
        logic unframed_bypass;
        logic cas_search;
        logic crc_mf_search;
        logic nfas_loss_criterion;
        logic ts16_zero_check_en;
        logic ts16_zero_count_sel;
    } efsc_ctrl_t;

    localparam efsc_mode_primary_t MODE_PRIMARY_RESET = 8'h06;
    localparam efsc_mode_criteria_t MODE_CRITERIA_RESET = 8'hE0;
    localparam efsc_sync_t SYNC_STATE_RESET = 5'h0D;
    localparam efsc_sync_t SYNC_ZERO = 5'h00;
    localparam efsc_pulse_t PULSE_ZERO = 2'h0;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam int CLK_PERIOD_PS = 5000;
    localparam int FRAME_PERIOD_NS = 125000;
    localparam int FRAME_PERIOD_CYCLES = (FRAME_PERIOD_NS * 1000) / CLK_PERIOD_PS;
    localparam int PHASE_W = 15;

endpackage

//--- efsc_frame_sync_ctrl.sv
// Control, status and interrupt logic of the receive frame sync processor, reached over AXI4-Lite.
// Function
// - Receive pulse offset flag drives the interrupt only while its enable is set.
// - Transmit pulse offset flag drives the interrupt only while its enable is set.
// - Unframed bit set makes the received stream bypass the frame processor.
// - Excessive CRC-4 errors restart the search when both reframe enables are set.
// - With auto reframe off, only the software force bit starts a search.
// - With auto reframe on, loss of basic frame sync starts a new search.
// - A written 0-to-1 change of the force bit starts one search.
// - Loss criterion bit selects FAS only or FAS and NFAS errors for sync loss.
// - CAS multiframe search runs only when enabled and basic frame is in sync.
// - CRC multiframe search runs only when enabled and basic frame is in sync.
// - Word and NFAS selectors choose which errors make a frame error event.
// - CAS multiframe loss criteria: pattern errors, optional all-zero TS16 for one or two.
// - CRC multiframe search stops under interworking unless the keep bit is set.
// - Interwork status bit reads 1 while interworking mode is active.
// - CAS, CRC multiframe and basic frame loss bits read 1 when lost, reset 1.
// - Offline frame loss bit reads 1 when lost and resets to 0.
// - Five enables, reset 0, gate the five sync change flags onto the interrupt.
// - Receive pulse interval not a multiple of 125 us sets a write-1-clear flag.
// - Any change of a sync status bit sets its write-1-clear change flag.
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module efsc_frame_sync_ctrl #(
    parameter int FRAME_PERIOD_CYCLES = efsc_pkg::FRAME_PERIOD_CYCLES
) (
    input wire logic SYS_CLK,
    input wire logic SRST,
    input wire logic [efsc_pkg::ADDR_W-1:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [efsc_pkg::ADDR_W-1:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    input wire logic RX_FRAME_PULSE,
    input wire logic TX_PULSE_OFFSET_EVT,
    input wire efsc_pkg::efsc_sync_t SYNC_STATUS,
    input wire logic EXCESS_CRC_EVT,
    input wire logic FAS_BIT_ERR,
    input wire logic FAS_PATTERN_ERR,
    input wire logic NFAS_ERR,
    output efsc_pkg::efsc_ctrl_t CTRL,
    output logic REFRAME_START,
    output logic FRAME_ERR_EVT,
    output logic IRQ_O,
    output logic IRQ_OE
);
    import efsc_pkg::*;

    localparam logic [PHASE_W-1:0] PHASE_LAST = PHASE_W'(FRAME_PERIOD_CYCLES - 1);

    function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] addr);
        word_index = addr[9:2];
    endfunction

    function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
        logic [7:0] idx;
        idx = word_index(addr);
        is_mapped = (addr[ADDR_W-1:10] == '0) && ((idx >= IDX_PULSE_FLAGS && idx <= IDX_SYNC_IRQ_EN)
                    || idx == IDX_SYNC_FLAGS);
    endfunction

    logic aw_held;
    logic [ADDR_W-1:0] awaddr_q;
    logic w_held;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_fire;
    logic wr_en;
    logic [7:0] wr_idx;
    efsc_pulse_t pulse_irq_en;
    efsc_mode_primary_t mode_primary;
    efsc_mode_criteria_t mode_criteria;
    efsc_sync_t sync_irq_en;
    efsc_sync_t sync_state;
    efsc_sync_t sync_flag;
    efsc_sync_t sync_set;
    efsc_sync_t sync_clr;
    efsc_pulse_t pulse_flag;
    efsc_pulse_t pulse_set;
    efsc_pulse_t pulse_clr;
    logic force_rise;
    logic frame_loss_rise;
    logic [2:0] rx_pulse_sync;
    logic rx_pulse_edge;
    logic rx_pulse_seen;
    logic [PHASE_W-1:0] rx_phase;
    logic next_irq;
    logic [7:0] rd_byte;

    // Write channel: address and data are held separately so either may arrive first.
    assign AWREADY = !aw_held && !BVALID;
    assign WREADY = !w_held && !BVALID;
    assign wr_fire = aw_held && w_held && !BVALID;
    assign wr_idx = word_index(awaddr_q);
    assign wr_en = wr_fire && wstrb_q[0] && is_mapped(awaddr_q);

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            aw_held <= 1'b0;
            awaddr_q <= '0;
        end else if (AWVALID && AWREADY) begin
            aw_held <= 1'b1;
            awaddr_q <= AWADDR;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            w_held <= 1'b0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else if (WVALID && WREADY) begin
            w_held <= 1'b1;
            wdata_q <= WDATA;
            wstrb_q <= WSTRB;
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            BVALID <= 1'b0;
            BRESP <= RESP_OKAY;
        end else if (wr_fire) begin
            BVALID <= 1'b1;
            BRESP <= is_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
        end else if (BREADY) begin
            BVALID <= 1'b0;
        end
    end

    // Writable control registers; reserved bits stay zero.
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            pulse_irq_en <= PULSE_ZERO;
            mode_primary <= MODE_PRIMARY_RESET;
            mode_criteria <= MODE_CRITERIA_RESET;
            sync_irq_en <= SYNC_ZERO;
        end else if (wr_en) begin
            case (wr_idx)
                IDX_PULSE_IRQ_EN: pulse_irq_en <= wdata_q[1:0];
                IDX_MODE_PRIMARY: mode_primary <= {4'h0, wdata_q[3:0]};
                IDX_MODE_CRITERIA: mode_criteria <= wdata_q[7:0];
                IDX_SYNC_IRQ_EN: sync_irq_en <= wdata_q[4:0];
                default: ;
            endcase
        end
    end

    // The force bit is only stored; the search request comes from its rising write.
    assign force_rise = wr_en && wr_idx == IDX_MODE_PRIMARY && wdata_q[0] && !mode_primary.force_reframe;

    // Read channel: one read in flight, data registered at acceptance.
    assign ARREADY = !RVALID;

    always_comb begin
        case (word_index(ARADDR))
            IDX_PULSE_FLAGS: rd_byte = {6'h00, pulse_flag};
            IDX_PULSE_IRQ_EN: rd_byte = {6'h00, pulse_irq_en};
            IDX_MODE_PRIMARY: rd_byte = mode_primary;
            IDX_MODE_CRITERIA: rd_byte = mode_criteria;
            IDX_SYNC_STATE: rd_byte = {3'h0, sync_state};
            IDX_SYNC_IRQ_EN: rd_byte = {3'h0, sync_irq_en};
            IDX_SYNC_FLAGS: rd_byte = {3'h0, sync_flag};
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            RVALID <= 1'b0;
            RDATA <= '0;
            RRESP <= RESP_OKAY;
        end else if (ARVALID && ARREADY) begin
            RVALID <= 1'b1;
            RDATA <= is_mapped(ARADDR) ? {24'h000000, rd_byte} : 32'h00000000;
            RRESP <= is_mapped(ARADDR) ? RESP_OKAY : RESP_SLVERR;
        end else if (RREADY) begin
            RVALID <= 1'b0;
        end
    end

    // Sync status follows the engine; the CAS, CRC multiframe and basic frame loss bits start out of sync after reset.
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            sync_state <= SYNC_STATE_RESET;
        end else begin
            sync_state <= SYNC_STATUS;
        end
    end

    // A change in either direction sets the flag; a set in the clearing cycle wins.
    assign sync_set = sync_state ^ SYNC_STATUS;
    assign sync_clr = (wr_en && wr_idx == IDX_SYNC_FLAGS) ? efsc_sync_t'(wdata_q[4:0]) : SYNC_ZERO;

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            sync_flag <= SYNC_ZERO;
        end else begin
            sync_flag <= (sync_flag & ~sync_clr) | sync_set;
        end
    end

    // The frame pulse pin is asynchronous; stage 0 feeds only stage 1.
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            rx_pulse_sync <= 3'h0;
        end else begin
            rx_pulse_sync <= {rx_pulse_sync[1:0], RX_FRAME_PULSE};
        end
    end

    assign rx_pulse_edge = rx_pulse_sync[1] && !rx_pulse_sync[2];

    // The phase counts cycles since the last pulse modulo the frame period, so any
    // whole number of frames between pulses lands exactly on the last phase.
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            rx_phase <= '0;
            rx_pulse_seen <= 1'b0;
        end else if (rx_pulse_edge) begin
            rx_phase <= '0;
            rx_pulse_seen <= 1'b1;
        end else begin
            rx_phase <= (rx_phase == PHASE_LAST) ? '0 : rx_phase + 1'b1;
        end
    end

    assign pulse_set.rx = rx_pulse_edge && rx_pulse_seen && rx_phase != PHASE_LAST;
    assign pulse_set.tx = TX_PULSE_OFFSET_EVT;
    assign pulse_clr = (wr_en && wr_idx == IDX_PULSE_FLAGS) ? efsc_pulse_t'(wdata_q[1:0]) : PULSE_ZERO;

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            pulse_flag <= PULSE_ZERO;
        end else begin
            pulse_flag <= (pulse_flag & ~pulse_clr) | pulse_set;
        end
    end

    // Interrupt pin is open drain: the pin is pulled low while the enable is high.
    assign next_irq = |(sync_flag & sync_irq_en) || (pulse_flag.rx && pulse_irq_en.rx)
                      || (pulse_flag.tx && pulse_irq_en.tx);
    assign IRQ_O = 1'b0;

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            IRQ_OE <= 1'b0;
        end else begin
            IRQ_OE <= next_irq;
        end
    end

    // Search requests; automatic causes are blocked when the framer is locked in frame.
    assign frame_loss_rise = SYNC_STATUS.frame_loss && !sync_state.frame_loss;

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            REFRAME_START <= 1'b0;
        end else begin
            REFRAME_START <= force_rise
                || (mode_primary.auto_reframe_en && frame_loss_rise)
                || (mode_primary.auto_reframe_en && mode_primary.crc_error_reframe_en && EXCESS_CRC_EVT);
        end
    end

    // Error events only count while the basic frame is in sync.
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            FRAME_ERR_EVT <= 1'b0;
        end else begin
            FRAME_ERR_EVT <= !sync_state.frame_loss
                && ((mode_criteria.whole_word_error ? FAS_PATTERN_ERR : FAS_BIT_ERR)
                    || (mode_criteria.include_nfas_errors && NFAS_ERR));
        end
    end

    // Configuration handed to the alignment engines.
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            CTRL <= '0;
        end else begin
            CTRL.unframed_bypass <= mode_primary.unframed_bypass;
            CTRL.cas_search <= mode_criteria.cas_search_en && !sync_state.frame_loss;
            CTRL.crc_mf_search <= mode_criteria.crc_mf_search_en && !sync_state.frame_loss
                && (mode_criteria.interwork_search_keep || !sync_state.interwork);
            CTRL.nfas_loss_criterion <= mode_criteria.nfas_loss_criterion;
            CTRL.ts16_zero_check_en <= mode_criteria.ts16_zero_check_en;
            CTRL.ts16_zero_count_sel <= mode_criteria.ts16_zero_count_sel;
        end
    end

    sequence s_rx_enabled_flag;
        pulse_flag.rx && pulse_irq_en.rx;
    endsequence

    property p_rx_offset_irq;
        @(posedge SYS_CLK) disable iff (SRST)
        s_rx_enabled_flag |=> IRQ_OE;
    endproperty
    a_rx_offset_irq: assert property (p_rx_offset_irq) else $error("rx offset flag enabled but no irq");

    property p_tx_offset_mask;
        @(posedge SYS_CLK) disable iff (SRST)
        (!pulse_irq_en.tx && !pulse_flag.rx && sync_flag == SYNC_ZERO) |=> !IRQ_OE;
    endproperty
    a_tx_offset_mask: assert property (p_tx_offset_mask) else $error("irq driven with nothing enabled");

    property p_bypass_follows;
        @(posedge SYS_CLK) disable iff (SRST)
        ##1 CTRL.unframed_bypass == $past(mode_primary.unframed_bypass);
    endproperty
    a_bypass_follows: assert property (p_bypass_follows) else $error("bypass does not follow mode bit");

    property p_crc_reframe;
        @(posedge SYS_CLK) disable iff (SRST)
        (EXCESS_CRC_EVT && mode_primary.auto_reframe_en && mode_primary.crc_error_reframe_en) |=> REFRAME_START;
    endproperty
    a_crc_reframe: assert property (p_crc_reframe) else $error("excess crc did not restart search");

    property p_locked_in_frame;
        @(posedge SYS_CLK) disable iff (SRST)
        (!mode_primary.auto_reframe_en && !force_rise) |=> !REFRAME_START;
    endproperty
    a_locked_in_frame: assert property (p_locked_in_frame) else $error("search started while locked");

    sequence s_force_write;
        wr_en && wr_idx == IDX_MODE_PRIMARY && wdata_q[0];
    endsequence

    property p_force_edge;
        @(posedge SYS_CLK) disable iff (SRST)
        (s_force_write and !mode_primary.force_reframe) |=> REFRAME_START ##1 mode_primary.force_reframe[*1];
    endproperty
    a_force_edge: assert property (p_force_edge) else $error("force write did not start search");

    property p_frame_err_gated;
        @(posedge SYS_CLK) disable iff (SRST)
        sync_state.frame_loss |=> !FRAME_ERR_EVT;
    endproperty
    a_frame_err_gated: assert property (p_frame_err_gated) else $error("frame error while out of sync");

    property p_change_sets_flag;
        @(posedge SYS_CLK) disable iff (SRST)
        (SYNC_STATUS.cas_mf_loss != sync_state.cas_mf_loss) |=> sync_flag.cas_mf_loss
            ##1 (sync_flag.cas_mf_loss || $past(sync_clr.cas_mf_loss));
    endproperty
    a_change_sets_flag: assert property (p_change_sets_flag) else $error("status change lost");

    property p_crc_search_interwork;
        @(posedge SYS_CLK) disable iff (SRST)
        (sync_state.interwork && !mode_criteria.interwork_search_keep) |=> !CTRL.crc_mf_search;
    endproperty
    a_crc_search_interwork: assert property (p_crc_search_interwork) else $error("crc search under interworking");

    property p_rx_offset_set;
        @(posedge SYS_CLK) disable iff (SRST)
        (rx_pulse_edge && rx_pulse_seen && rx_phase != PHASE_LAST) |=> pulse_flag.rx;
    endproperty
    a_rx_offset_set: assert property (p_rx_offset_set) else $error("offset pulse interval not flagged");

endmodule

`default_nettype wire

//--- efsc_engine_model.sv
// Partner model of the frame alignment engine and of the receive frame pulse source.
`timescale 1ns/10ps
`default_nettype none

module efsc_engine_model (
    input wire logic SYS_CLK,
    output efsc_pkg::efsc_sync_t SYNC_STATUS,
    output logic EXCESS_CRC_EVT,
    output logic FAS_BIT_ERR,
    output logic FAS_PATTERN_ERR,
    output logic NFAS_ERR,
    output logic TX_PULSE_OFFSET_EVT,
    output logic RX_FRAME_PULSE
);
    import efsc_pkg::*;

    initial begin
        SYNC_STATUS = SYNC_STATE_RESET;
        {EXCESS_CRC_EVT, FAS_BIT_ERR, FAS_PATTERN_ERR, NFAS_ERR, TX_PULSE_OFFSET_EVT, RX_FRAME_PULSE} = 6'h00;
    end

    // Status levels change only at a clock edge, as the engine's own registers would.
    task automatic set_status(input efsc_sync_t s);
        @(posedge SYS_CLK);
        SYNC_STATUS <= s;
    endtask

    // Bits 4 to 0: excessive CRC, FAS bit, FAS pattern, NFAS, transmit offset; each lasts one cycle.
    task automatic fire(input logic [4:0] m);
        @(posedge SYS_CLK);
        {EXCESS_CRC_EVT, FAS_BIT_ERR, FAS_PATTERN_ERR, NFAS_ERR, TX_PULSE_OFFSET_EVT} <= m;
        @(posedge SYS_CLK);
        {EXCESS_CRC_EVT, FAS_BIT_ERR, FAS_PATTERN_ERR, NFAS_ERR, TX_PULSE_OFFSET_EVT} <= 5'h00;
    endtask

    // The pin is asynchronous to the block, so it is held high for two cycles to survive the synchroniser.
    task automatic rx_pulse(input int gap);
        @(posedge SYS_CLK);
        RX_FRAME_PULSE <= 1'b1;
        repeat (2) @(posedge SYS_CLK);
        RX_FRAME_PULSE <= 1'b0;
        repeat (gap - 3) @(posedge SYS_CLK);
    endtask
endmodule

`default_nettype wire

//--- tb_efsc_frame_sync_ctrl.sv
// Self-checking testbench of the frame sync control block.
`timescale 1ns/10ps
`default_nettype none

module tb_efsc_frame_sync_ctrl;
    import efsc_pkg::*;

    localparam int PERIOD = 16;
    localparam logic [7:0] REG_IDX [7] = '{IDX_PULSE_FLAGS, IDX_PULSE_IRQ_EN, IDX_MODE_PRIMARY, IDX_MODE_CRITERIA,
        IDX_SYNC_STATE, IDX_SYNC_IRQ_EN, IDX_SYNC_FLAGS};
    localparam logic [7:0] REG_RST [7] = '{8'h00, 8'h00, 8'h06, 8'hE0, 8'h0D, 8'h00, 8'h00};
    logic SYS_CLK = 1'b0;
    logic SRST = 1'b1;
    logic [ADDR_W-1:0] AWADDR = '0;
    logic [ADDR_W-1:0] ARADDR = '0;
    logic [31:0] WDATA = '0;
    logic [3:0] WSTRB = 4'hF;
    logic AWVALID = 1'b0;
    logic WVALID = 1'b0;
    logic BREADY = 1'b0;
    logic ARVALID = 1'b0;
    logic RREADY = 1'b0;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
    logic [1:0] BRESP, RRESP;
    logic [31:0] RDATA;
    logic RX_FRAME_PULSE, TX_PULSE_OFFSET_EVT, EXCESS_CRC_EVT, FAS_BIT_ERR, FAS_PATTERN_ERR, NFAS_ERR;
    logic REFRAME_START, FRAME_ERR_EVT, IRQ_O, IRQ_OE;
    efsc_sync_t SYNC_STATUS;
    efsc_sync_t s;
    efsc_ctrl_t CTRL;
    int failures = 0;
    int n_checks = 0;
    int seed = 32'h87F2631D;
    logic [33:0] rd_q[$];
    logic [33:0] b_q[$];
    logic [1:0] p_q[$];
    logic [7:0] c, m;

    efsc_frame_sync_ctrl #(.FRAME_PERIOD_CYCLES(PERIOD)) dut (.SYS_CLK, .SRST, .AWADDR, .AWVALID, .AWREADY,
        .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA,
        .RRESP, .RVALID, .RREADY, .RX_FRAME_PULSE, .TX_PULSE_OFFSET_EVT, .SYNC_STATUS, .EXCESS_CRC_EVT,
        .FAS_BIT_ERR, .FAS_PATTERN_ERR, .NFAS_ERR, .CTRL, .REFRAME_START, .FRAME_ERR_EVT, .IRQ_O, .IRQ_OE);

    efsc_engine_model eng (.SYS_CLK, .SYNC_STATUS, .EXCESS_CRC_EVT, .FAS_BIT_ERR, .FAS_PATTERN_ERR, .NFAS_ERR,
        .TX_PULSE_OFFSET_EVT, .RX_FRAME_PULSE);

    always #2.5 SYS_CLK = ~SYS_CLK;

    task automatic cmp_bus(input logic [33:0] got, input logic [33:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_pulse(input logic [1:0] got, input logic [1:0] exp);
        cmp_bus({32'h0, got}, {32'h0, exp});
    endtask

    task automatic cmp_lvl(input logic [7:0] got, input logic [7:0] exp);
        cmp_bus({26'h0, got}, {26'h0, exp});
    endtask

    task automatic complete_run;
        if (failures == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Levels are sampled on the falling edge, where nothing launched by the rising edge is still moving.
    task automatic chk_lvl(input bit sel, input logic [7:0] exp);
        repeat (4) @(posedge SYS_CLK);
        @(negedge SYS_CLK);
        cmp_lvl(sel ? {2'h0, CTRL} : {7'h0, IRQ_OE}, exp);
        @(posedge SYS_CLK);
    endtask

    task automatic axw(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] r);
        logic aw_ok, w_ok, b_ok;
        logic b_done;
        b_done = 1'b0;
        b_q.push_back({r, 32'h0});
        AWADDR <= {2'h0, idx, 2'h0};
        WDATA <= {24'h0, d};
        WSTRB <= 4'($random(seed)) | 4'h1;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'($random(seed));
        while (AWVALID || WVALID || BREADY || !b_done) begin
            @(negedge SYS_CLK);
            aw_ok = AWVALID && AWREADY === 1'b1;
            w_ok = WVALID && WREADY === 1'b1;
            b_ok = BREADY && BVALID === 1'b1;
            @(posedge SYS_CLK);
            if (aw_ok) AWVALID <= 1'b0;
            if (w_ok) WVALID <= 1'b0;
            if (b_ok) BREADY <= 1'b0;
            else if (!b_done) BREADY <= 1'b1;
            b_done = b_done || b_ok;
        end
    endtask

    task automatic axr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] r);
        logic ar_ok, r_ok;
        logic r_done;
        r_done = 1'b0;
        rd_q.push_back({r, 24'h0, d});
        ARADDR <= {2'h0, idx, 2'h0};
        ARVALID <= 1'b1;
        RREADY <= 1'($random(seed));
        while (ARVALID || RREADY || !r_done) begin
            @(negedge SYS_CLK);
            ar_ok = ARVALID && ARREADY === 1'b1;
            r_ok = RREADY && RVALID === 1'b1;
            @(posedge SYS_CLK);
            if (ar_ok) ARVALID <= 1'b0;
            if (r_ok) RREADY <= 1'b0;
            else if (!r_done) RREADY <= 1'b1;
            r_done = r_done || r_ok;
        end
    endtask

    // A result with no note behind it is compared against an impossible value so that it is reported.
    always @(negedge SYS_CLK) begin
        if (BVALID === 1'b1 && BREADY === 1'b1) begin
            cmp_bus({BRESP, 32'h0}, b_q.size() ? b_q.pop_front() : '1);
        end
        if (RVALID === 1'b1 && RREADY === 1'b1) begin
            cmp_bus({RRESP, RDATA}, rd_q.size() ? rd_q.pop_front() : '1);
        end
        if (REFRAME_START !== 1'b0 || FRAME_ERR_EVT !== 1'b0) begin
            cmp_pulse({REFRAME_START, FRAME_ERR_EVT}, p_q.size() ? p_q.pop_front() : 2'h0);
        end
    end

    initial begin
        #200000;
        failures++;
        complete_run;
    end

    initial begin
        repeat (10) @(posedge SYS_CLK);
        SRST <= 1'b0;
        @(posedge SYS_CLK);
        chk_lvl(1, 8'h04);
        cmp_lvl({7'h0, IRQ_O}, 8'h00);
        for (int i = 0; i < 7; i++) axr(REG_IDX[i], REG_RST[i], RESP_OKAY);
        axr(8'h60, 8'h00, RESP_SLVERR);
        axw(8'h60, 8'hFF, RESP_SLVERR);
        for (int i = 0; i < 4; i++) begin
            c = 8'($random(seed));
            axw(IDX_PULSE_IRQ_EN, c & 8'h03, RESP_OKAY);
            axr(IDX_PULSE_IRQ_EN, c & 8'h03, RESP_OKAY);
            axw(IDX_SYNC_IRQ_EN, c & 8'h1F, RESP_OKAY);
            axr(IDX_SYNC_IRQ_EN, c & 8'h1F, RESP_OKAY);
        end
        axw(IDX_SYNC_IRQ_EN, 8'h00, RESP_OKAY);
        axw(IDX_PULSE_IRQ_EN, 8'h00, RESP_OKAY);
        // Bypass on and automatic reframe off, so loss changes below start no search.
        axw(IDX_MODE_PRIMARY, 8'h08, RESP_OKAY);
        for (int i = 0; i < 8; i++) begin
            c = 8'($random(seed));
            s = efsc_sync_t'({i[0], 3'h0, i[1]});
            eng.set_status(s);
            axw(IDX_MODE_CRITERIA, c, RESP_OKAY);
            axr(IDX_MODE_CRITERIA, c, RESP_OKAY);
            chk_lvl(1, {3'h1, c[6] & !s.frame_loss, c[5] & !s.frame_loss & (c[0] | !s.interwork),
                c[7], c[1], c[2]});
        end
        axw(IDX_MODE_PRIMARY, 8'h06, RESP_OKAY);
        eng.set_status(SYNC_ZERO);
        p_q.push_back(2'h2);
        axw(IDX_MODE_PRIMARY, 8'h07, RESP_OKAY);
        axw(IDX_MODE_PRIMARY, 8'h07, RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            m = {5'h0, i[1:0], 1'b0};
            axw(IDX_MODE_PRIMARY, m, RESP_OKAY);
            if (m == 8'h06) p_q.push_back(2'h2);
            eng.fire(5'h10);
            if (m[1]) p_q.push_back(2'h2);
            eng.set_status(efsc_sync_t'(5'h01));
            eng.set_status(SYNC_ZERO);
        end
        axw(IDX_MODE_PRIMARY, 8'h00, RESP_OKAY);
        p_q.push_back(2'h2);
        axw(IDX_MODE_PRIMARY, 8'h01, RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            axw(IDX_MODE_CRITERIA, {3'h7, i[0], i[1], 3'h0}, RESP_OKAY);
            for (int k = 0; k < 3; k++) begin
                if ((k == 0 && !i[1]) || (k == 1 && i[1]) || (k == 2 && i[0])) p_q.push_back(2'h1);
                eng.fire(5'h08 >> k);
            end
        end
        eng.set_status(efsc_sync_t'(5'h01));
        eng.fire(5'h0E);
        eng.set_status(SYNC_ZERO);
        axw(IDX_SYNC_FLAGS, 8'h1F, RESP_OKAY);
        axw(IDX_PULSE_FLAGS, 8'h03, RESP_OKAY);
        chk_lvl(0, 8'h00);
        s = SYNC_ZERO;
        for (int i = 0; i < 5; i++) begin
            m = 8'h01 << i;
            c = 8'h01 << ((i + 1) % 5);
            axw(IDX_SYNC_IRQ_EN, m, RESP_OKAY);
            s = efsc_sync_t'(s ^ c[4:0]);
            eng.set_status(s);
            chk_lvl(0, 8'h00);
            s = efsc_sync_t'(s ^ m[4:0]);
            eng.set_status(s);
            chk_lvl(0, 8'h01);
            axr(IDX_SYNC_STATE, {3'h0, s}, RESP_OKAY);
            axr(IDX_SYNC_FLAGS, m | c, RESP_OKAY);
            axw(IDX_SYNC_FLAGS, m, RESP_OKAY);
            chk_lvl(0, 8'h00);
            axw(IDX_SYNC_FLAGS, c, RESP_OKAY);
        end
        axw(IDX_SYNC_IRQ_EN, 8'h00, RESP_OKAY);
        axw(IDX_PULSE_IRQ_EN, 8'h01, RESP_OKAY);
        eng.fire(5'h01);
        chk_lvl(0, 8'h01);
        axr(IDX_PULSE_FLAGS, 8'h01, RESP_OKAY);
        axw(IDX_PULSE_IRQ_EN, 8'h02, RESP_OKAY);
        chk_lvl(0, 8'h00);
        axw(IDX_PULSE_FLAGS, 8'h01, RESP_OKAY);
        repeat (4) eng.rx_pulse(PERIOD);
        chk_lvl(0, 8'h00);
        // The check above stretches the next interval to a value between one and two periods.
        eng.rx_pulse(PERIOD);
        chk_lvl(0, 8'h01);
        axr(IDX_PULSE_FLAGS, 8'h02, RESP_OKAY);
        axw(IDX_PULSE_IRQ_EN, 8'h00, RESP_OKAY);
        chk_lvl(0, 8'h00);
        repeat (5) @(posedge SYS_CLK);
        cmp_lvl(8'(p_q.size()), 8'h00);
        complete_run;
    end
endmodule

`default_nettype wire
